// ### inc/tec_pkg.sv
// Package for the 8-bit timer/event counter: register map, fields, resets.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package tec_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_PRELOAD = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0C;
    // Control register field positions
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int RUN_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int PSC_MSB = 2;
    localparam int PSC_LSB = 0;
    // Interrupt-control register field positions
    localparam int IE_BIT = 0;
    localparam int IRQ_FLAG_BIT = 1;
    localparam int WAKE_FLAG_BIT = 2;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h08;
    localparam logic [7:0] PRELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // Mode codes
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;
    // Counter full value
    localparam logic [7:0] COUNT_FULL = 8'hFF;
    // Prescaler width (divide up to 2^7)
    localparam int PSC_W = 7;
    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [2:0] {
        CAP_IDLE = 3'b001,
        CAP_ARMED = 3'b010,
        CAP_COUNT = 3'b100
    } tec_cap_t;
endpackage

// ### logic/tec_prescaler.sv
// Free-running prescaler giving a one-cycle tick on each falling edge
// of the divided clock. Assumes one clock domain, hclk.
module tec_prescaler #(
    parameter int WIDTH = tec_pkg::PSC_W
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Rate select: divide by 2**sel
    input wire logic [2:0] sel,
    // Tick at each high-to-low transition of the divided clock
    output logic tick
);
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic tick_d;

    if (WIDTH != 7) begin : g_width_check
        $error("tec_prescaler needs WIDTH 7");
    end

    always_comb begin
        cnt_d = cnt_q + 7'h01;
        // Divided clock bit sel-1 falls when the low sel bits wrap to zero
        if (sel == 3'h0) begin
            tick_d = 1'b1;
        end else begin
            tick_d = ((cnt_d & ((7'h01 << sel) - 7'h01)) == 7'h00);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 7'h00;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // tec_prescaler

// ### logic/tec_timer.sv
// 8-bit count-up timer / event counter / pulse width capture with an
// AHB-Lite register slave. Assumes hclk at 100 MHz, the timer pin is
// asynchronous, and an interrupt controller outside takes irq and wake.
//
// How it works
// - Mode 01 events, 10 timer, 11 capture.
// - Control bit 5 always reads zero.
// - Run bit enables counting; resets to zero.
// - Event mode: edge bit picks falling/rising.
// - Capture: edge bit picks start/stop edges.
// - Prescaler divides by two to the field.
// - Timer mode counts prescaled falling transitions.
// - Overflow: interrupt, reload preload, keep counting.
// - Overflow wakes device; enable gates interrupt.
// - Event mode ignores the prescaler.
// - Event counting continues during sleep.
// - Capture: run bit only arms the counter.
// - Capture end clears run bit, holds count.
// - Timer/event modes never self-clear run bit.
// - After capture, pin ignored until rearmed.
// - Capture triggered by edges, not levels.
// - Capture samples prescaler each clock cycle.
// - Count up to FFH, overflow past it.
// - Preload write loads counter when stopped.
// - Counter read or preload write inhibits count.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
module tec_timer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer input pin, asynchronous
    input wire logic timer_input_pin,
    // Interrupt request and wake-up, one-cycle pulses
    output logic irq,
    output logic wake
);
    // Bus address phase capture
    logic wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic rd_cnt_q, rd_cnt_d;
    logic [31:0] hrdata_d;
    // Registers
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] preload_q, preload_d;
    logic [7:0] count_q, count_d;
    logic ie_q, ie_d;
    logic irq_flag_q, irq_flag_d;
    logic wake_flag_q, wake_flag_d;
    logic irq_d, wake_d;
    // Pin synchroniser and edge detection
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic pin_rise, pin_fall;
    tec_pkg::tec_cap_t cap_q, cap_d;
    logic psc_tick;
    logic [1:0] mode;
    logic run, edge_sel, addr_ok, wr_now, pre_wr, inhibit, step, start_e, stop_e;

    // Active pin edge: falling when the select is one, rising otherwise
    function automatic logic pick_edge(input logic sel, input logic rise, input logic fall);
        return sel ? fall : rise;
    endfunction

    // A count step at the full value is an overflow
    function automatic logic ovf_hit(input logic stp, input logic [7:0] cnt);
        return stp && (cnt == tec_pkg::COUNT_FULL);
    endfunction

    // Control value as stored and read back; bit 5 is never set
    function automatic logic [7:0] ctrl_clean(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        r[5] = 1'b0;
        return r;
    endfunction

    tec_prescaler #(
        .WIDTH(tec_pkg::PSC_W)
    ) u_psc (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(ctrl_q[tec_pkg::PSC_MSB:tec_pkg::PSC_LSB]),
        .tick(psc_tick)
    );

    // Two-flop synchroniser, third flop for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= timer_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_s3_q;
    assign pin_fall = ~pin_s2_q & pin_s3_q;

    assign mode = {ctrl_q[tec_pkg::MODE_HI_BIT], ctrl_q[tec_pkg::MODE_LO_BIT]};
    assign run = ctrl_q[tec_pkg::RUN_BIT];
    assign edge_sel = ctrl_q[tec_pkg::EDGE_BIT];
    assign addr_ok = hsel & hready & (htrans == tec_pkg::HTRANS_NONSEQ);
    assign wr_now = wr_pend_q;
    assign pre_wr = wr_now && (addr_q == tec_pkg::ADDR_PRELOAD);
    assign inhibit = pre_wr || rd_cnt_q;
    assign start_e = pick_edge(~edge_sel, pin_rise, pin_fall);
    assign stop_e = pick_edge(edge_sel, pin_rise, pin_fall);

    // Bus address phase and read data
    always_comb begin
        wr_pend_d = addr_ok & hwrite;
        addr_d = addr_ok ? haddr : addr_q;
        rd_cnt_d = addr_ok & ~hwrite & (haddr == tec_pkg::ADDR_COUNT);
        hrdata_d = hrdata;
        if (addr_ok && !hwrite) begin
            if (haddr == tec_pkg::ADDR_CONTROL) begin
                hrdata_d = {24'h000000, ctrl_clean(ctrl_q)};
            end else if (haddr == tec_pkg::ADDR_PRELOAD) begin
                hrdata_d = {24'h000000, preload_q};
            end else if (haddr == tec_pkg::ADDR_COUNT) begin
                hrdata_d = {24'h000000, count_q};
            end else if (haddr == tec_pkg::ADDR_IRQ_CTRL) begin
                hrdata_d = {29'h0, wake_flag_q, irq_flag_q, ie_q};
            end else begin
                hrdata_d = 32'h00000000;
            end
        end
    end

    // Count source per mode; a count read or a preload write holds it still
    always_comb begin
        step = 1'b0;
        case (mode)
            tec_pkg::MODE_EVENT: begin
                step = run && pick_edge(edge_sel, pin_rise, pin_fall);
            end
            tec_pkg::MODE_TIMER: begin
                step = run && psc_tick;
            end
            tec_pkg::MODE_PULSE: begin
                step = (cap_q == tec_pkg::CAP_COUNT) && psc_tick;
            end
            default: begin
                step = 1'b0;
            end
        endcase
        // Each inhibited access drops any count step due in its cycle; software must allow for it
        if (inhibit) begin
            step = 1'b0;
        end
    end

    // Counter, control and capture sequencing
    always_comb begin
        ctrl_d = ctrl_q;
        preload_d = preload_q;
        count_d = count_q;
        ie_d = ie_q;
        irq_flag_d = irq_flag_q;
        wake_flag_d = wake_flag_q;
        cap_d = cap_q;
        irq_d = 1'b0;
        wake_d = 1'b0;
        // Capture sequencing; run bit is only armed by software
        // Leaving capture mode or clearing run drops back to idle
        case (cap_q)
            tec_pkg::CAP_IDLE: begin
                if (mode == tec_pkg::MODE_PULSE && run) begin
                    cap_d = tec_pkg::CAP_ARMED;
                end
            end
            tec_pkg::CAP_ARMED: begin
                if (mode != tec_pkg::MODE_PULSE || !run) begin
                    cap_d = tec_pkg::CAP_IDLE;
                end else if (start_e) begin
                    cap_d = tec_pkg::CAP_COUNT;
                end
            end
            tec_pkg::CAP_COUNT: begin
                if (mode != tec_pkg::MODE_PULSE || !run) begin
                    cap_d = tec_pkg::CAP_IDLE;
                end else if (stop_e) begin
                    cap_d = tec_pkg::CAP_IDLE;
                    ctrl_d[tec_pkg::RUN_BIT] = 1'b0;
                end
            end
            default: begin
                cap_d = tec_pkg::CAP_IDLE;
            end
        endcase
        if (step) begin
            if (ovf_hit(step, count_q)) begin
                count_d = preload_q;
                irq_flag_d = 1'b1;
                wake_flag_d = 1'b1;
                irq_d = ie_q;
                wake_d = 1'b1;
            end else begin
                count_d = count_q + 8'h01;
            end
        end
        // Register writes in the data phase
        if (wr_now) begin
            if (addr_q == tec_pkg::ADDR_CONTROL) begin
                ctrl_d = ctrl_clean(hwdata[7:0]);
                cap_d = tec_pkg::CAP_IDLE;
            end else if (addr_q == tec_pkg::ADDR_PRELOAD) begin
                preload_d = hwdata[7:0];
                // While running, the new value waits for the next overflow
                if (!run) begin
                    count_d = hwdata[7:0];
                end
            end else if (addr_q == tec_pkg::ADDR_IRQ_CTRL) begin
                ie_d = hwdata[tec_pkg::IE_BIT];
                // Write one to clear; a same-cycle overflow keeps the flag
                if (hwdata[tec_pkg::IRQ_FLAG_BIT] && !ovf_hit(step, count_q)) begin
                    irq_flag_d = 1'b0;
                end
                if (hwdata[tec_pkg::WAKE_FLAG_BIT] && !ovf_hit(step, count_q)) begin
                    wake_flag_d = 1'b0;
                end
            end
        end
    end

    // Bus front end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            rd_cnt_q <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rd_cnt_q <= rd_cnt_d;
            hrdata <= hrdata_d;
        end
    end

    // Control, counter and interrupt-control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= tec_pkg::CONTROL_RESET;
            preload_q <= tec_pkg::PRELOAD_RESET;
            count_q <= tec_pkg::COUNT_RESET;
            ie_q <= 1'b0;
            irq_flag_q <= 1'b0;
            wake_flag_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            preload_q <= preload_d;
            count_q <= count_d;
            ie_q <= ie_d;
            irq_flag_q <= irq_flag_d;
            wake_flag_q <= wake_flag_d;
        end
    end

    // Capture sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_q <= tec_pkg::CAP_IDLE;
        end else begin
            cap_q <= cap_d;
        end
    end

    // Overflow pulses, one cycle each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq <= irq_d;
            wake <= wake_d;
        end
    end

    // Zero-wait-state slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule // tec_timer

// ### test/tb_tec_timer.sv
// Self-checking bench for tec_timer: AHB-Lite tasks and pin source.
// Assumes a zero-wait slave and the checker bound in its own file.
module tb_tec_timer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_C = tec_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_P = tec_pkg::ADDR_PRELOAD;
    localparam logic [7:0] A_N = tec_pkg::ADDR_COUNT;
    localparam logic [7:0] A_I = tec_pkg::ADDR_IRQ_CTRL;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pin, irq, wake;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, keep;
    int err_count, checked, cyc, irqs, wakes;
    assign hready = hreadyout;
    tec_timer tec_timer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .timer_input_pin(pin), .irq, .wake);
    tec_pin_src tec_pin_src_inst (.hclk, .pin);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (cyc == 60000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= tec_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
        bus(a, 1'b0, 32'h0);
        chk(s, e, rd);
    endtask
    task automatic rng(input string s, input int lo, input int hi);
        checked++;
        if ((rd >= lo && rd <= hi) !== 1'b1) begin
            err_count++;
            $display("BAD %s exp %0d to %0d got %h", s, lo, hi, rd);
        end
    endtask
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            tec_pin_src_inst.drive(1'b1, w);
            tec_pin_src_inst.drive(1'b0, w);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {hresetn, hsel, hwrite} = '0;
        {haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(A_C, 32'h08, "ctrl reset");
        rdc(A_P, 32'h00, "preload reset");
        rdc(A_N, 32'h00, "count reset");
        rdc(A_I, 32'h00, "irqctl reset");
        rdc(8'h10, 32'h00, "unmapped");
        wr(A_C, 32'hFF);
        rdc(A_C, 32'hDF, "ctrl bit5");
        $display("test registers done");
        wr(A_C, 32'h40);
        wr(A_P, 32'hFC);
        rdc(A_N, 32'hFC, "stopped load");
        wr(A_I, 32'h01);
        wr(A_C, 32'h57);
        pulse(3, 4);
        rdc(A_N, 32'hFF, "rising count");
        pulse(1, 4);
        rdc(A_N, 32'hFC, "reload");
        rdc(A_I, 32'h07, "flags");
        chk("irq pulses", 32'd1, irqs);
        chk("wake pulses", 32'd1, wakes);
        rdc(A_C, 32'h57, "run kept");
        wr(A_I, 32'h07);
        rdc(A_I, 32'h01, "flags clear");
        wr(A_C, 32'h5F);
        tec_pin_src_inst.drive(1'b1, 6);
        rdc(A_N, 32'hFC, "rise ignored");
        tec_pin_src_inst.drive(1'b0, 6);
        rdc(A_N, 32'hFD, "fall count");
        wr(A_C, 32'h10);
        pulse(2, 4);
        rdc(A_N, 32'hFD, "mode none");
        wr(A_C, 32'h40);
        pulse(2, 4);
        rdc(A_N, 32'hFD, "run off");
        $display("test event done");
        for (int p = 0; p < 8; p++) begin
            wr(A_P, 32'h00);
            wr(A_C, 32'h90 | p);
            repeat (64 << p) @(posedge hclk);
            wr(A_C, 32'h80);
            bus(A_N, 1'b0, 32'h0);
            rng("timer count", 63, 67);
        end
        wr(A_P, 32'h00);
        wr(A_C, 32'h90);
        bus(A_N, 1'b0, 32'h0);
        keep = rd;
        bus(A_N, 1'b0, 32'h0);
        chk("read inhibit", 32'h1, rd - keep);
        wr(A_C, 32'h80);
        $display("test timer done");
        wr(A_I, 32'h06);
        wr(A_P, 32'hFE);
        keep = irqs;
        wr(A_C, 32'h90);
        repeat (8) @(posedge hclk);
        wr(A_C, 32'h80);
        bus(A_I, 1'b0, 32'h0);
        chk("wake flag", 32'h04, rd & 32'h05);
        chk("masked irq", keep, irqs);
        $display("test mask done");
        wr(A_P, 32'h00);
        wr(A_C, 32'hD8);
        repeat (10) @(posedge hclk);
        rdc(A_N, 32'h00, "armed");
        tec_pin_src_inst.drive(1'b1, 20);
        tec_pin_src_inst.drive(1'b0, 6);
        rdc(A_C, 32'hC8, "run cleared");
        bus(A_N, 1'b0, 32'h0);
        rng("width", 18, 22);
        keep = rd;
        pulse(1, 6);
        rdc(A_N, keep, "one shot");
        tec_pin_src_inst.drive(1'b1, 4);
        wr(A_C, 32'hD8);
        repeat (10) @(posedge hclk);
        rdc(A_N, keep, "level only");
        wr(A_C, 32'hC0);
        wr(A_P, 32'h00);
        wr(A_C, 32'hD0);
        tec_pin_src_inst.drive(1'b0, 12);
        tec_pin_src_inst.drive(1'b1, 6);
        rdc(A_C, 32'hC0, "run cleared low");
        bus(A_N, 1'b0, 32'h0);
        rng("width low", 10, 14);
        $display("test capture done");
        complete_run();
    end
endmodule // tb_tec_timer

// ### test/tec_pin_src.sv
// Model of the event or pulse source on the timer pin.
// Assumes drive is called just after a rising edge of hclk.
module tec_pin_src (
    // Clock
    input wire logic hclk,
    // Timer pin, always driven as an input level
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // Holds each level for n cycles; callers keep n at 2 or more
    task automatic drive(input logic lvl, input int n);
        pin <= lvl;
        repeat (n) @(posedge hclk);
    endtask
endmodule // tec_pin_src

// ### test/tec_timer_properties.sv
// Port checker for tec_timer, bound to every instance.
// Assumes whole-word writes and irq_ctrl bit 0 as the interrupt enable.
module tec_timer_properties (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Overflow outputs
    input wire logic irq,
    input wire logic wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take, wc_d, wc_q, wi_d, wi_q, ie_d, ie_q;
    logic [3:0] ctl_d, ctl_q;
    logic [1:0] off_d, off_q;
    assign take = hsel && hready && htrans == tec_pkg::HTRANS_NONSEQ;
    // Shadow of mode, run and enable; off_q counts cycles stopped or in no mode
    always_comb begin
        wc_d = take && hwrite && haddr == tec_pkg::ADDR_CONTROL;
        wi_d = take && hwrite && haddr == tec_pkg::ADDR_IRQ_CTRL;
        ctl_d = wc_q ? hwdata[7:4] : ctl_q;
        ie_d = wi_q ? hwdata[tec_pkg::IE_BIT] : ie_q;
        off_d = (ctl_q[3:2] != tec_pkg::MODE_NONE && ctl_q[0]) ? 2'h0 :
                (off_q == 2'h3) ? 2'h3 : off_q + 2'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wc_q, wi_q, ctl_q, ie_q, off_q} <= '0;
        end else begin
            {wc_q, wi_q, ctl_q, ie_q, off_q} <= {wc_d, wi_d, ctl_d, ie_d, off_d};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [7:0] a); take && !hwrite && haddr == a; endsequence
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_bit5; s_rd(tec_pkg::ADDR_CONTROL) |=> hrdata[5] == 1'b0; endproperty
    a_bit5: assert property (p_bit5) else $error("control bit 5 set");
    property p_upper; take && !hwrite |=> hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmap; take && !hwrite && haddr > 8'h0C |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pair; irq |-> wake; endproperty
    a_pair: assert property (p_pair) else $error("irq without wake");
    property p_idle; off_q == 2'h3 |-> !wake; endproperty
    a_idle: assert property (p_idle) else $error("overflow while idle");
    property p_mask; !ie_q && !$past(ie_q) |-> !irq; endproperty
    a_mask: assert property (p_mask) else $error("irq while disabled");
    property p_irq; ie_q && $past(ie_q) && wake |-> irq; endproperty
    a_irq: assert property (p_irq) else $error("enabled irq missing");
endmodule // tec_timer_properties

bind tec_timer tec_timer_properties tec_timer_properties_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .wake);
